/* File: hw/ldz_pkg.sv */
package ldz_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_DDLY = 8'h04;
   localparam logic [7:0] ADDR_ZINFO = 8'h08;
   localparam logic [7:0] ADDR_TGT = 8'h0c;
   localparam logic [7:0] ADDR_STAT = 8'h10;
   localparam logic [7:0] ADDR_MASK = 8'h14;
   // control and zone info field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_DD_BIT = 1;
   localparam int CTRL_AVG_LSB = 2;
   localparam int ZINFO_FLAG_BIT = 3;
   // reset values
   localparam logic [4:0] CTRL_RST = 5'h00;
   localparam logic [4:0] DDLY_RST = 5'h00;
   localparam logic [1:0] MASK_RST = 2'h0;
   // zone decision constants
   localparam logic [5:0] UP_PERIODS = 6'h03;
   localparam logic [5:0] DN_BASE_PERIODS = 6'h06;
   localparam logic [1:0] FAST_PERIODS = 2'h3;
   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int FAST_PERIOD_NS = 1100000;
   localparam int FAST_CYC_DEF = FAST_PERIOD_NS / CLK_PERIOD_NS;
   // sequencing states, gray along idle-fast-run
   typedef enum logic [1:0] {
      LDZ_IDLE = 2'h0,
      LDZ_FAST = 2'h1,
      LDZ_RUN = 2'h3
   } ldz_state_e;
   // apb request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } ldz_apb_s;
endpackage : ldz_pkg

/* File: hw/ldz_zone_ctrl.sv */
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module ldz_zone_ctrl #(
   parameter int FAST_CYC = ldz_pkg::FAST_CYC_DEF
) (
   input wire logic clock,
   input wire logic rst,
   input wire ldz_pkg::ldz_apb_s apb_req,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic [2:0] avg_zone,
   output logic period_start,
   output logic fast_mode,
   output logic [2:0] target_zone,
   output logic int_n_out,
   output logic int_n_oe,
   output logic irq
);

   // register state
   logic [4:0] ctrl_ff, nxt_ctrl;
   logic [4:0] ddly_ff, nxt_ddly;
   logic [1:0] stat_ff, nxt_stat;
   logic [1:0] mask_ff, nxt_mask;
   logic pready_ff, nxt_pready;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pslverr_ff, nxt_pslverr;
   logic irq_ff, nxt_irq;
   // zone decision state
   ldz_pkg::ldz_state_e state_ff, nxt_state;
   logic [23:0] per_cnt_ff, nxt_per_cnt;
   logic [1:0] fast_left_ff, nxt_fast_left;
   logic [2:0] ao_ff, nxt_ao;
   logic [2:0] tgt_ff, nxt_tgt;
   logic [5:0] cnt_ff, nxt_cnt;
   logic cnt_up_ff, nxt_cnt_up;
   logic qual_ff, nxt_qual;
   logic qual_up_ff, nxt_qual_up;
   logic [2:0] zinfo_ff, nxt_zinfo;
   logic zflag_ff, nxt_zflag;
   logic pstart_ff, nxt_pstart;
   logic fast_ff, nxt_fast;
   // shared strobes
   logic access, rd_info, tick, zev, tev;
   logic chg_up, chg_dn, rel_up, rel_dn;
   logic [5:0] req;
   logic en, dd_mode;
   logic [2:0] avg_sel;

   assign en = ctrl_ff[ldz_pkg::CTRL_EN_BIT];
   assign dd_mode = ctrl_ff[ldz_pkg::CTRL_DD_BIT];
   assign avg_sel = ctrl_ff[ldz_pkg::CTRL_AVG_LSB +: 3];
   assign access = apb_req.psel && apb_req.penable && pready_ff;
   assign rd_info = access && !apb_req.pwrite && apb_req.paddr == ldz_pkg::ADDR_ZINFO;
   assign tick = state_ff != ldz_pkg::LDZ_IDLE && per_cnt_ff == 24'h000000;
   assign zev = tick && avg_zone != ao_ff;
   assign tev = tick && nxt_tgt != tgt_ff;
   // direction of the new zone against the last output and the target
   assign chg_up = avg_zone > ao_ff;
   assign chg_dn = avg_zone < ao_ff;
   assign rel_up = avg_zone > tgt_ff;
   assign rel_dn = avg_zone < tgt_ff;
   // periods needed to move the target
   assign req = (rel_dn && dd_mode) ? (6'(ddly_ff) + ldz_pkg::DN_BASE_PERIODS)
                                    : ldz_pkg::UP_PERIODS;

   // apb slave, registers and interrupt status
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_ddly = ddly_ff;
      nxt_mask = mask_ff;
      nxt_stat = stat_ff;
      nxt_pready = apb_req.psel && !apb_req.penable; // answer in first access cycle
      nxt_prdata = prdata_ff;
      nxt_pslverr = 1'b0;
      if (apb_req.psel && !apb_req.penable) begin
         nxt_prdata = 32'h00000000;
         unique case (apb_req.paddr)
            ldz_pkg::ADDR_CTRL: nxt_prdata[4:0] = ctrl_ff;
            ldz_pkg::ADDR_DDLY: nxt_prdata[4:0] = ddly_ff;
            ldz_pkg::ADDR_ZINFO: nxt_prdata[3:0] = {zflag_ff, zinfo_ff};
            ldz_pkg::ADDR_TGT: nxt_prdata[3:0] = {fast_mode, tgt_ff};
            ldz_pkg::ADDR_STAT: nxt_prdata[1:0] = stat_ff;
            ldz_pkg::ADDR_MASK: nxt_prdata[1:0] = mask_ff;
            default: nxt_pslverr = 1'b1;
         endcase
      end
      if (access && apb_req.pwrite) begin
         unique case (apb_req.paddr)
            ldz_pkg::ADDR_CTRL: nxt_ctrl = apb_req.pwdata[4:0];
            ldz_pkg::ADDR_DDLY: nxt_ddly = apb_req.pwdata[4:0];
            ldz_pkg::ADDR_STAT: nxt_stat = stat_ff & ~apb_req.pwdata[1:0];
            ldz_pkg::ADDR_MASK: nxt_mask = apb_req.pwdata[1:0];
            default: ;
         endcase
      end
      // events set after the clear so they win
      nxt_stat = nxt_stat | {tev, zev};
      nxt_irq = |(nxt_stat & nxt_mask);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_ff <= ldz_pkg::CTRL_RST;
         ddly_ff <= ldz_pkg::DDLY_RST;
         mask_ff <= ldz_pkg::MASK_RST;
         stat_ff <= 2'h0;
         pready_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
         pslverr_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         ddly_ff <= nxt_ddly;
         mask_ff <= nxt_mask;
         stat_ff <= nxt_stat;
         pready_ff <= nxt_pready;
         prdata_ff <= nxt_prdata;
         pslverr_ff <= nxt_pslverr;
         irq_ff <= nxt_irq;
      end
   end

   // period timing, zone qualification and zone interrupt
   always_comb begin
      nxt_state = state_ff;
      nxt_per_cnt = per_cnt_ff;
      nxt_fast_left = fast_left_ff;
      nxt_ao = ao_ff;
      nxt_tgt = tgt_ff;
      nxt_cnt = cnt_ff;
      nxt_cnt_up = cnt_up_ff;
      nxt_qual = qual_ff;
      nxt_qual_up = qual_up_ff;
      nxt_zinfo = zinfo_ff;
      nxt_zflag = rd_info ? 1'b0 : zflag_ff;
      nxt_pstart = tick;
      unique case (state_ff)
         ldz_pkg::LDZ_IDLE: begin
            if (en) begin
               nxt_state = ldz_pkg::LDZ_FAST;
               nxt_fast_left = ldz_pkg::FAST_PERIODS;
               nxt_per_cnt = 24'(FAST_CYC - 1);
            end
         end
         ldz_pkg::LDZ_FAST, ldz_pkg::LDZ_RUN: begin
            nxt_per_cnt = per_cnt_ff - 24'h000001;
            if (tick) begin
               if (state_ff == ldz_pkg::LDZ_FAST && fast_left_ff == 2'h1) begin
                  nxt_state = ldz_pkg::LDZ_RUN;
               end
               nxt_fast_left = fast_left_ff - 2'h1;
               if (nxt_state == ldz_pkg::LDZ_FAST) begin
                  nxt_per_cnt = 24'(FAST_CYC - 1);
               end else begin
                  nxt_per_cnt = (24'(FAST_CYC) << avg_sel) - 24'h000001;
               end
               nxt_ao = avg_zone;
               if (qual_ff && (qual_up_ff ? chg_up : chg_dn)) begin
                  nxt_tgt = avg_zone;
                  nxt_cnt = 6'h00;
               end else begin
                  nxt_qual = 1'b0;
                  nxt_cnt_up = rel_up;
                  if (cnt_ff != 6'h00 && cnt_up_ff == rel_up && (rel_up || rel_dn)
                      && !(rel_up ? chg_dn : chg_up)) begin
                     nxt_cnt = cnt_ff + 6'h01;
                  end else if ((chg_up && rel_up) || (chg_dn && rel_dn)) begin
                     nxt_cnt = 6'h01;
                  end else begin
                     nxt_cnt = 6'h00;
                  end
                  if (nxt_cnt != 6'h00 && nxt_cnt == req) begin
                     nxt_tgt = avg_zone;
                     nxt_qual = 1'b1;
                     nxt_qual_up = rel_up;
                     nxt_cnt = 6'h00;
                  end
               end
               if (zev) begin
                  nxt_zinfo = avg_zone;
                  nxt_zflag = 1'b1;
               end
            end
         end
         default: nxt_state = ldz_pkg::LDZ_IDLE;
      endcase
      if (!en) begin
         nxt_state = ldz_pkg::LDZ_IDLE;
         nxt_cnt = 6'h00;
         nxt_qual = 1'b0;
         nxt_per_cnt = 24'h000000;
         nxt_pstart = 1'b0;
      end
      if (state_ff == ldz_pkg::LDZ_IDLE) begin
         nxt_ao = 3'h0;
         nxt_tgt = 3'h0;
         nxt_cnt = 6'h00;
         nxt_qual = 1'b0;
      end
      // startup flag kept in its own flop so the output is not a state decode
      nxt_fast = nxt_state == ldz_pkg::LDZ_FAST;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_ff <= ldz_pkg::LDZ_IDLE;
         per_cnt_ff <= 24'h000000;
         fast_left_ff <= 2'h0;
         ao_ff <= 3'h0;
         tgt_ff <= 3'h0;
         cnt_ff <= 6'h00;
         cnt_up_ff <= 1'b0;
         qual_ff <= 1'b0;
         qual_up_ff <= 1'b0;
         zinfo_ff <= 3'h0;
         zflag_ff <= 1'b0;
         pstart_ff <= 1'b0;
         fast_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         per_cnt_ff <= nxt_per_cnt;
         fast_left_ff <= nxt_fast_left;
         ao_ff <= nxt_ao;
         tgt_ff <= nxt_tgt;
         cnt_ff <= nxt_cnt;
         cnt_up_ff <= nxt_cnt_up;
         qual_ff <= nxt_qual;
         qual_up_ff <= nxt_qual_up;
         zinfo_ff <= nxt_zinfo;
         zflag_ff <= nxt_zflag;
         pstart_ff <= nxt_pstart;
         fast_ff <= nxt_fast;
      end
   end

   // outputs from flip-flops, int_n_out tied low; pin driven low while the flag stands
   assign pready = pready_ff;
   assign prdata = prdata_ff;
   assign pslverr = pslverr_ff;
   assign period_start = pstart_ff;
   assign fast_mode = fast_ff;
   assign target_zone = tgt_ff;
   assign int_n_out = 1'b0;
   assign int_n_oe = zflag_ff;
   assign irq = irq_ff;

   // checks
   sequence s_dn_tick;
      tick && rel_dn && !qual_ff && cnt_ff != 6'h00 && !cnt_up_ff;
   endsequence

   a_start_zero: assert property (@(posedge clock) disable iff (rst)
      state_ff == ldz_pkg::LDZ_IDLE && en |=> ao_ff == 3'h0 && tgt_ff == 3'h0 && cnt_ff == 6'h00)
      else $error("zone not zero at start");
   a_fast_end: assert property (@(posedge clock) disable iff (rst)
      en && tick && state_ff == ldz_pkg::LDZ_FAST && fast_left_ff == 2'h1
      |=> state_ff == ldz_pkg::LDZ_RUN)
      else $error("fast startup did not end after three periods");
   a_tgt_at_tick: assert property (@(posedge clock) disable iff (rst)
      state_ff != ldz_pkg::LDZ_IDLE && tgt_ff != $past(tgt_ff) |-> $past(tick))
      else $error("target changed outside period start");
   a_dn_delay: assert property (@(posedge clock) disable iff (rst)
      s_dn_tick ##0 (dd_mode && cnt_ff + 6'h01 < 6'(ddly_ff) + 6'h06) |=> tgt_ff == $past(tgt_ff))
      else $error("lower target loaded before delay count");
   a_up_third: assert property (@(posedge clock) disable iff (rst)
      tick && !qual_ff && rel_up && cnt_up_ff && cnt_ff == 6'h02 && !chg_dn
      |=> tgt_ff == $past(avg_zone))
      else $error("upward change missed on third period");
   a_cancel_dn: assert property (@(posedge clock) disable iff (rst)
      s_dn_tick ##0 chg_up |=> tgt_ff == $past(tgt_ff) && cnt_ff == 6'h00)
      else $error("pending decrease not cancelled");
   a_zone_event: assert property (@(posedge clock) disable iff (rst)
      zev |=> zflag_ff && int_n_oe && zinfo_ff == $past(avg_zone))
      else $error("zone interrupt not raised");
   a_read_clear: assert property (@(posedge clock) disable iff (rst)
      rd_info && !zev |=> !zflag_ff && !int_n_oe)
      else $error("zone info read did not clear flag");
   a_off_clear: assert property (@(posedge clock) disable iff (rst)
      !en |=> cnt_ff == 6'h00 && !qual_ff && state_ff == ldz_pkg::LDZ_IDLE)
      else $error("counters not cleared when disabled");

endmodule : ldz_zone_ctrl
`default_nettype wire

/* File: dv/ldz_avg_model.sv */
`timescale 1ns/1ns
`default_nettype none
// averager stand-in: shows one zone per full period, moving on at each period start
module ldz_avg_model (
   input wire logic clock,
   input wire logic period_start,
   output logic [2:0] avg_zone
);
   logic [2:0] sched[$];
   int loads = 0;
   int taken = 0;
   // load a schedule; the first entry is the zone of the first full period
   task automatic load(input logic [2:0] z[$]);
      sched = z;
      loads++;
   endtask : load
   // a fresh schedule shows its first zone at once; later zones only after the tick took the last
   always @(posedge clock) begin
      if (taken != loads && sched.size() > 0) begin
         taken <= loads;
         avg_zone <= sched.pop_front();
      end else if (period_start && sched.size() > 0) begin
         avg_zone <= sched.pop_front();
      end
   end
endmodule : ldz_avg_model
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin error_cnt++; \
   $display("mismatch %s exp %h got %h", nm, ex, got); end end
module tb_top;
   localparam int FC = 20;
   logic clock;
   logic rst;
   ldz_pkg::ldz_apb_s req;
   logic pready;
   logic [31:0] prdata;
   logic pslverr;
   logic [2:0] avg_zone;
   logic period_start;
   logic fast_mode;
   logic [2:0] target_zone;
   logic int_n_out;
   logic int_n_oe;
   logic irq;
   wire logic int_pin;
   int error_cnt = 0;
   int num_checks = 0;
   // interrupt wire has a pull-up and is only pulled low by the block
   assign int_pin = int_n_oe ? int_n_out : 1'b1;
   ldz_zone_ctrl #(.FAST_CYC(FC)) u_dut (.clock(clock), .rst(rst), .apb_req(req),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .avg_zone(avg_zone),
      .period_start(period_start), .fast_mode(fast_mode), .target_zone(target_zone),
      .int_n_out(int_n_out), .int_n_oe(int_n_oe), .irq(irq));
   ldz_avg_model u_avg (.clock(clock), .period_start(period_start), .avg_zone(avg_zone));
   // clock source
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   task automatic finish_test();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : finish_test
   // one apb transfer: setup, then access held until pready is sampled high
   task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clock);
      req <= '{1'b1, 1'b0, wr_en, a, wd};
      @(posedge clock);
      req.penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
      end
      rd = prdata;
      err = pslverr;
      req <= '0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
   endtask : wr
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] ex);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0, rd, err);
      `CHK(nm, ex, rd)
   endtask : rdc
   // wait for the next period start, counting cycles since the last one
   task automatic tick(output int gap);
      gap = 0;
      do begin
         @(negedge clock);
         gap++;
      end while (period_start !== 1'b1 && gap < 2000);
      if (gap >= 2000) begin
         error_cnt++;
      end
   endtask : tick
   task automatic regs();
      logic [31:0] rd;
      logic err;
      rdc("ctrl reset", ldz_pkg::ADDR_CTRL, 32'h0);
      rdc("delay reset", ldz_pkg::ADDR_DDLY, 32'h0);
      rdc("mask reset", ldz_pkg::ADDR_MASK, 32'h0);
      wr(ldz_pkg::ADDR_DDLY, 32'h1f);
      rdc("delay max", ldz_pkg::ADDR_DDLY, 32'h1f);
      apb(1'b0, 8'h18, 32'h0, rd, err);
      `CHK("unmapped err", 1'b1, err)
      `CHK("unmapped data", 32'h0, rd)
   endtask : regs
   task automatic irq_chk();
      logic [2:0] q[$];
      int gap;
      q = '{3'h0, 3'h3, 3'h3, 3'h3};
      wr(ldz_pkg::ADDR_MASK, 32'h1);
      u_avg.load(q);
      wr(ldz_pkg::ADDR_CTRL, 32'h1);
      tick(gap);
      `CHK("pin idle", 1'b1, int_pin)
      tick(gap);
      `CHK("pin pulled", 1'b0, int_pin)
      `CHK("irq raised", 1'b1, irq)
      rdc("zone info", ldz_pkg::ADDR_ZINFO, 32'hb);
      @(negedge clock);
      `CHK("pin released", 1'b1, int_pin)
      rdc("flag cleared", ldz_pkg::ADDR_ZINFO, 32'h3);
      rdc("status", ldz_pkg::ADDR_STAT, 32'h1);
      wr(ldz_pkg::ADDR_MASK, 32'h0);
      @(negedge clock);
      `CHK("irq masked", 1'b0, irq)
      wr(ldz_pkg::ADDR_MASK, 32'h1);
      wr(ldz_pkg::ADDR_STAT, 32'h1);
      @(negedge clock);
      `CHK("irq cleared", 1'b0, irq)
   endtask : irq_chk
   // restart with a zone schedule, one hex digit per period, checking the target each period
   task automatic play(input logic [4:0] ctrl, input logic [4:0] code, input int n,
         input logic [47:0] z, input logic [47:0] t);
      logic [2:0] q[$];
      int gap;
      int k;
      wr(ldz_pkg::ADDR_CTRL, 32'h0);
      wr(ldz_pkg::ADDR_DDLY, {27'h0, code});
      for (k = 0; k < n; k++) begin
         q.push_back(z[4 * (n - 1 - k) +: 3]);
      end
      u_avg.load(q);
      wr(ldz_pkg::ADDR_CTRL, {27'h0, ctrl});
      @(negedge clock);
      `CHK("target at start", 3'h0, target_zone)
      for (k = 0; k < n; k++) begin
         tick(gap);
         if (k > 0) `CHK("period length", (k < 3) ? FC : FC * 2, gap)
         if (k == 0 || k == 3) `CHK("fast mode", k == 0, fast_mode)
         `CHK("target", t[4 * (n - 1 - k) +: 3], target_zone)
      end
      rdc("target reg", ldz_pkg::ADDR_TGT, {28'h0, 1'b0, t[2:0]});
   endtask : play
   // watchdog
   initial begin
      #2000000;
      error_cnt++;
      finish_test();
   end
   initial begin
      rst = 1'b1;
      req = '0;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      regs();
      irq_chk();
      play(5'h05, 5'h00, 9, 48'h011122111, 48'h000122221);
      play(5'h07, 5'h00, 10, 48'h0444111111, 48'h0004444441);
      play(5'h07, 5'h02, 12, 48'h044422222222, 48'h000444444442);
      play(5'h07, 5'h00, 12, 48'h044411111444, 48'h000444444444);
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
